// ---- design/efr_flags.sv ----
// Purpose: sticky write-one-to-clear error flags for serial, map and ROM faults
// Assumes: all inputs but reset_n_i synchronous to clk_i; enable word held by a companion register
// Notes:   flags_o mirrors the flag flops; unimplemented bits read zero
//
// Operation
// - a read to a nonexistent address sets the invalid-read flag.
// - a write to a nonexistent address sets the invalid-write flag.
// - a checksum mismatch on a received transaction sets the frame checksum flag at bit 2.
// - while bit 1 is enabled a checksum over the register map is taken at a fixed interval.
// - the map checksum flag is set when the map changed with no legitimate write made.
// - after power-up the ROM checksum is computed once and reported at bit 0.
// - the ROM flag is set when the ROM checksum differs from the expected value.
// - a flag only sets while its enable bit is set.
// - flags reset to zero, read one when set, and clear only by writing one.
// - a frame whose clock edge count is not a multiple of eight sets the clock-count flag.
`timescale 1ns/1ps
module efr_flags #(
  parameter int unsigned MAP_W      = 128,
  parameter int unsigned ROM_W      = 256,
  parameter int unsigned PERIOD_CYC = efr_pkg::REGMAP_PERIOD_CYC
) (
  // clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        reset_n_i,
  // register access
  input  wire logic                        wr_i,
  input  wire logic [efr_pkg::FLAG_W-1:0]  wr_data_i,
  input  wire logic [efr_pkg::FLAG_W-1:0]  err_en_i,
  output logic      [efr_pkg::FLAG_W-1:0]  flags_o,
  // serial interface events
  input  wire efr_pkg::efr_spi_evt_t       spi_evt_i,
  input  wire logic                        frame_active_i,
  input  wire logic                        sclk_edge_i,
  // register map and rom contents
  input  wire logic [MAP_W-1:0]            regmap_i,
  input  wire logic                        regmap_wr_i,
  input  wire logic [ROM_W-1:0]            rom_i,
  input  wire logic [7:0]                  rom_crc_ref_i
);
  localparam int unsigned TMR_W = $clog2(PERIOD_CYC + 1);

  logic                        rst_s1_q;
  logic                        rst_s2_q;
  logic [efr_pkg::FLAG_W-1:0]  flags_q;
  logic [efr_pkg::FLAG_W-1:0]  set_d;
  logic [efr_pkg::FLAG_W-1:0]  clr_d;
  logic [2:0]                  edge_cnt_q;
  logic                        frame_q;
  logic                        frame_end;
  logic [TMR_W-1:0]            tmr_q;
  logic                        tick;
  logic [7:0]                  map_ref_q;
  logic                        map_ref_ok_q;
  logic [7:0]                  map_crc;
  logic                        map_bad;
  efr_pkg::efr_boot_t          boot_q;
  logic                        rom_bad;

  function automatic logic [7:0] crc8(input logic [ROM_W-1:0] data, input int unsigned n);
    logic [7:0] c;
    c = efr_pkg::CRC_SEED;
    for (int unsigned i = 0; i < ROM_W; i++) begin
      if (i < n) begin
        c = (c[7] ^ data[i]) ? ({c[6:0], 1'b0} ^ efr_pkg::CRC_POLY) : {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction : crc8

  // reset release through two flops
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // clock edge count per frame, modulo eight
  assign frame_end = frame_q && !frame_active_i;
  always_ff @(posedge clk_i or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      frame_q    <= 1'b0;
      edge_cnt_q <= efr_pkg::EDGE_CNT_ZERO;
    end else begin
      frame_q <= frame_active_i;
      if (frame_active_i && !frame_q) begin
        edge_cnt_q <= {2'h0, sclk_edge_i};
      end else if (frame_active_i && sclk_edge_i) begin
        edge_cnt_q <= edge_cnt_q + 3'h1;
      end
    end
  end

  // interval timer for the map check, idle while disabled
  assign tick = (tmr_q == TMR_W'(PERIOD_CYC - 1));
  always_ff @(posedge clk_i or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      tmr_q <= '0;
    end else if (!err_en_i[efr_pkg::BIT_REGMAP_CRC] || tick) begin
      tmr_q <= '0;
    end else begin
      tmr_q <= tmr_q + TMR_W'(1);
    end
  end

  // map reference; a legitimate write makes the next sample a fresh reference
  assign map_crc = crc8(ROM_W'(regmap_i), MAP_W);
  assign map_bad = tick && map_ref_ok_q && !regmap_wr_i && (map_crc != map_ref_q);
  always_ff @(posedge clk_i or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      map_ref_q    <= 8'h00;
      map_ref_ok_q <= 1'b0;
    end else if (!err_en_i[efr_pkg::BIT_REGMAP_CRC] || regmap_wr_i) begin
      map_ref_ok_q <= 1'b0;
    end else if (tick) begin
      map_ref_q    <= map_crc;
      map_ref_ok_q <= 1'b1;
    end
  end

  // one-shot rom check after reset release
  assign rom_bad = (boot_q == efr_pkg::BOOT_CHECK) && (crc8(rom_i, ROM_W) != rom_crc_ref_i);
  always_ff @(posedge clk_i or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      boot_q <= efr_pkg::BOOT_CHECK;
    end else begin
      case (boot_q)
        efr_pkg::BOOT_CHECK: boot_q <= efr_pkg::BOOT_DONE;
        default:             boot_q <= efr_pkg::BOOT_DONE;
      endcase
    end
  end

  // flag set and clear terms
  always_comb begin
    set_d = '0;
    set_d[efr_pkg::BIT_INV_READ]   = spi_evt_i.rd_invalid;
    set_d[efr_pkg::BIT_INV_WRITE]  = spi_evt_i.wr_invalid;
    set_d[efr_pkg::BIT_FRAME_CRC]  = spi_evt_i.crc_bad;
    set_d[efr_pkg::BIT_CLK_COUNT]  = frame_end && (edge_cnt_q != efr_pkg::EDGE_CNT_ZERO);
    set_d[efr_pkg::BIT_REGMAP_CRC] = map_bad;
    set_d[efr_pkg::BIT_ROM_CRC]    = rom_bad;
    set_d = set_d & err_en_i & efr_pkg::FLAGS_IMPL;
    clr_d = wr_i ? wr_data_i : '0;
  end

  // sticky flags; a set in the clearing cycle wins
  always_ff @(posedge clk_i or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      flags_q <= efr_pkg::FLAGS_RESET;
    end else begin
      flags_q <= (flags_q & ~clr_d) | set_d;
    end
  end

  assign flags_o = flags_q;

  // checks
  sequence frame_bad_s;
    frame_end && (edge_cnt_q != efr_pkg::EDGE_CNT_ZERO)
      && err_en_i[efr_pkg::BIT_CLK_COUNT];
  endsequence
  sequence clear_req_s(int b);
    wr_i && wr_data_i[b];
  endsequence

  inv_read_set_a: assert property (@(posedge clk_i) disable iff (!rst_s2_q)
    spi_evt_i.rd_invalid && err_en_i[efr_pkg::BIT_INV_READ] |=> flags_o[efr_pkg::BIT_INV_READ])
    else $error("invalid read not flagged");
  inv_write_set_a: assert property (@(posedge clk_i) disable iff (!rst_s2_q)
    spi_evt_i.wr_invalid && err_en_i[efr_pkg::BIT_INV_WRITE] |=> flags_o[efr_pkg::BIT_INV_WRITE])
    else $error("invalid write not flagged");
  frame_crc_set_a: assert property (@(posedge clk_i) disable iff (!rst_s2_q)
    spi_evt_i.crc_bad && err_en_i[efr_pkg::BIT_FRAME_CRC] |=> flags_o[2])
    else $error("frame checksum error not flagged");
  map_tick_gap_a: assert property (@(posedge clk_i) disable iff (!rst_s2_q)
    tick |=> !tick [*1] ##0 (tmr_q == TMR_W'(0)))
    else $error("map check interval wrong");
  map_flag_cause_a: assert property (@(posedge clk_i) disable iff (!rst_s2_q)
    $rose(flags_o[efr_pkg::BIT_REGMAP_CRC]) |-> $past(tick) && !$past(regmap_wr_i))
    else $error("map flag set without a check");
  rom_once_a: assert property (@(posedge clk_i) disable iff (!rst_s2_q)
    (boot_q == efr_pkg::BOOT_CHECK) |=> (boot_q == efr_pkg::BOOT_DONE) [*2])
    else $error("rom check not one-shot");
  rom_flag_a: assert property (@(posedge clk_i) disable iff (!rst_s2_q)
    rom_bad && err_en_i[efr_pkg::BIT_ROM_CRC] |=> flags_o[0])
    else $error("rom mismatch not flagged");
  enable_gate_a: assert property (@(posedge clk_i) disable iff (!rst_s2_q)
    (flags_o & ~$past(flags_o) & ~$past(err_en_i)) == '0)
    else $error("flag set while disabled");
  clear_only_a: assert property (@(posedge clk_i) disable iff (!rst_s2_q)
    $fell(flags_o[efr_pkg::BIT_INV_READ]) |-> $past(wr_i && wr_data_i[efr_pkg::BIT_INV_READ]))
    else $error("flag cleared without a write of one");
  clear_works_a: assert property (@(posedge clk_i) disable iff (!rst_s2_q)
    clear_req_s(efr_pkg::BIT_FRAME_CRC) ##0 !set_d[efr_pkg::BIT_FRAME_CRC]
      |=> !flags_o[efr_pkg::BIT_FRAME_CRC])
    else $error("write of one did not clear");
  clk_count_a: assert property (@(posedge clk_i) disable iff (!rst_s2_q)
    frame_bad_s |=> flags_o[efr_pkg::BIT_CLK_COUNT])
    else $error("odd clock count not flagged");
endmodule : efr_flags

// ---- shared/efr_pkg.sv ----
// Purpose: shared constants and types for the error flag register tail
// Assumes: one 40 MHz clock, flags packed into a 16-bit word
// Notes:   enable bits sit at the same positions as their flags
package efr_pkg;
  localparam int unsigned         FLAG_W          = 16;
  // flag bit positions
  localparam int unsigned         BIT_ROM_CRC     = 0;
  localparam int unsigned         BIT_REGMAP_CRC  = 1;
  localparam int unsigned         BIT_FRAME_CRC   = 2;
  localparam int unsigned         BIT_INV_WRITE   = 4;
  localparam int unsigned         BIT_CLK_COUNT   = 5;
  localparam int unsigned         BIT_INV_READ    = 6;
  localparam logic [FLAG_W-1:0]   FLAGS_RESET     = 16'h0000;
  localparam logic [FLAG_W-1:0]   FLAGS_IMPL      = 16'h0077;
  // clock edges per serial byte
  localparam int unsigned         EDGE_CNT_W      = 3;
  localparam logic [2:0]          EDGE_CNT_ZERO   = 3'h0;
  // checksum
  localparam logic [7:0]          CRC_POLY        = 8'h07;
  localparam logic [7:0]          CRC_SEED        = 8'hFF;
  // timing
  localparam int unsigned         CLK_PERIOD_NS   = 25;
  localparam int unsigned         REGMAP_PERIOD_NS = 100000;
  localparam int unsigned         REGMAP_PERIOD_CYC = REGMAP_PERIOD_NS / CLK_PERIOD_NS;

  // serial-interface fault pulses, one per transaction
  typedef struct packed {
    logic rd_invalid;
    logic wr_invalid;
    logic crc_bad;
  } efr_spi_evt_t;

  // boot sequence for the one-shot ROM check
  typedef enum logic [1:0] {
    BOOT_CHECK = 2'b01,
    BOOT_DONE  = 2'b10
  } efr_boot_t;
endpackage : efr_pkg

// ---- sim/efr_host_model.sv ----
// Purpose: host side that clears error flags by writing ones
// Assumes: one clock shared with the flag register
// Notes:   one write cycle per clear request
`timescale 1ns/1ps
module efr_host_model (
  // clock and request
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        clr_i,
  input  wire logic [15:0] mask_i,
  // register write
  output logic             wr_o,
  output logic      [15:0] wr_data_o
);
  // one write strobe per clear request, data holds the ones to clear
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_o      <= 1'b0;
      wr_data_o <= 16'h0000;
    end else begin
      wr_o      <= clr_i;
      wr_data_o <= clr_i ? mask_i : 16'h0000;
    end
  end
endmodule : efr_host_model

// ---- sim/test_efr_flags.sv ----
// Purpose: self-checking bench for the error flag register
// Assumes: map check interval shortened to 8 cycles
// Notes:   rom input held constant, rom reference varied across resets
`timescale 1ns/1ps
module test_efr_flags;
  typedef struct {logic [2:0] evt; logic [15:0] en; logic [15:0] exp;} efr_row_t;
  logic clk_i = 0, reset_n_i = 1, clr = 0, frame_active_i = 0, sclk_edge_i = 0;
  logic regmap_wr_i = 0, wr_i;
  logic [15:0] err_en_i = 0, mask = 0, flags_o, wr_data_i;
  logic [127:0] regmap_i = 0;
  logic [7:0] ref_q = 0;
  efr_pkg::efr_spi_evt_t spi_evt_i = '0;
  int n_errors = 0, checked = 0;
  efr_row_t rows[5] = '{'{3'b100, 16'h0040, 16'h0040}, '{3'b010, 16'h0010, 16'h0010},
    '{3'b001, 16'h0004, 16'h0004}, '{3'b001, 16'h0040, 16'h0000},
    '{3'b111, 16'hFFFF, 16'h0054}};
  always #12.5 clk_i = ~clk_i;
  efr_host_model u_efr_host_model (.clk_i(clk_i), .reset_n_i(reset_n_i), .clr_i(clr),
    .mask_i(mask), .wr_o(wr_i), .wr_data_o(wr_data_i));
  efr_flags #(.PERIOD_CYC(8)) u_efr_flags (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .wr_i(wr_i), .wr_data_i(wr_data_i), .err_en_i(err_en_i), .flags_o(flags_o),
    .spi_evt_i(spi_evt_i), .frame_active_i(frame_active_i), .sclk_edge_i(sclk_edge_i),
    .regmap_i(regmap_i), .regmap_wr_i(regmap_wr_i), .rom_i(256'h0), .rom_crc_ref_i(ref_q));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc
  task automatic chk(input logic [15:0] exp, input string what);
    checked++;
    if (flags_o !== exp) begin
      n_errors++;
      $display("ERROR %0t %s exp=%h got=%h", $time, what, exp, flags_o);
    end
  endtask : chk
  task automatic clear(input logic [15:0] m);
    @(posedge clk_i) begin clr <= 1; mask <= m; end
    @(posedge clk_i) clr <= 0;
    cyc(3);
  endtask : clear
  // expected checksum of an all-zero rom of n bits
  function automatic logic [7:0] rom_crc(input int n);
    logic [7:0] c;
    c = efr_pkg::CRC_SEED;
    repeat (n) c = c[7] ? ({c[6:0], 1'b0} ^ efr_pkg::CRC_POLY) : {c[6:0], 1'b0};
    return c;
  endfunction : rom_crc
  task automatic do_reset(input logic [7:0] r);
    @(posedge clk_i) begin ref_q <= r; reset_n_i <= 1'b0; end
    repeat (7) @(posedge clk_i);
    @(posedge clk_i) reset_n_i <= 1'b1;
    cyc(6);
  endtask : do_reset
  task automatic pulse(input logic [2:0] e);
    @(posedge clk_i) spi_evt_i <= e;
    @(posedge clk_i) spi_evt_i <= '0;
    cyc(2);
  endtask : pulse
  task automatic frame(input int n);
    @(posedge clk_i) begin frame_active_i <= 1; sclk_edge_i <= 1; end
    repeat (n - 1) @(posedge clk_i);
    @(posedge clk_i) begin frame_active_i <= 0; sclk_edge_i <= 0; end
    cyc(3);
  endtask : frame
  task automatic end_sim;
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    reset_n_i <= 1'b0;
    do_reset(8'h00);
    chk(16'h0000, "reset");
    $display("test reset done");
    @(posedge clk_i) err_en_i <= 16'h0001;
    do_reset(rom_crc(256));
    chk(16'h0000, "rom match");
    do_reset(~rom_crc(256));
    chk(16'h0001, "rom mismatch");
    clear(16'hFFFF);
    chk(16'h0000, "rom clear");
    $display("test rom done");
    foreach (rows[i]) begin
      @(posedge clk_i) err_en_i <= rows[i].en;
      pulse(rows[i].evt);
      chk(rows[i].exp, "row");
      clear(16'hFFFF);
      $display("test row %0d done", i);
    end
    @(posedge clk_i) err_en_i <= 16'h0024;
    frame(9);
    chk(16'h0020, "odd frame");
    clear(16'h0020);
    frame(8);
    chk(16'h0000, "whole frame");
    pulse(3'b001);
    clear(16'h0020);
    chk(16'h0004, "clear other");
    clear(16'h0004);
    chk(16'h0000, "clear one");
    // event lands in the same cycle as the write of one; the set wins
    @(posedge clk_i) begin clr <= 1; mask <= 16'h0004; end
    @(posedge clk_i) begin clr <= 0; spi_evt_i <= 3'b001; end
    @(posedge clk_i) spi_evt_i <= '0;
    cyc(2);
    chk(16'h0004, "set wins");
    clear(16'h0004);
    chk(16'h0000, "set wins clear");
    $display("test frame and clear done");
    @(posedge clk_i) err_en_i <= 16'h0002;
    cyc(20);
    @(posedge clk_i) regmap_i <= 128'h5A;
    cyc(20);
    chk(16'h0002, "map corrupt");
    clear(16'h0002);
    @(posedge clk_i) begin regmap_i <= 128'hA5; regmap_wr_i <= 1; end
    @(posedge clk_i) regmap_wr_i <= 0;
    cyc(20);
    chk(16'h0000, "map written");
    $display("test map done");
    end_sim;
  end
  initial begin
    #(5000 * 25);
    n_errors++;
    end_sim;
  end
endmodule : test_efr_flags
